// >>> hdl/iar_pkg.sv
/*
  iar_pkg: shared types and constants for the io access router.
  assumes byte addresses of 32 bits and at most four host bridges.
*/
package iar_pkg;

  //////////////////////////////////////////////////////////////////////////
  // address landmarks
  localparam logic [31:0] IAR_LOW_WIN_BASE = 32'h000A_0000;
  localparam logic [31:0] IAR_LOW_WIN_LAST = 32'h000F_FFFF;
  localparam logic [31:0] IAR_ISA_MEM_LIMIT = 32'h0100_0000;
  localparam logic [31:0] IAR_ISA_IO_LIMIT = 32'h0001_0000;
  localparam logic [1:0] IAR_FIRST_BRIDGE = 2'h0;

  //////////////////////////////////////////////////////////////////////////
  // request source and destination kinds
  typedef enum logic [1:0] {
    IAR_SRC_ISA_DMA = 2'h0,
    IAR_SRC_ISA_MASTER = 2'h1,
    IAR_SRC_PCI_MASTER = 2'h3,
    IAR_SRC_HOST_BRIDGE = 2'h2
  } iar_src_t;

  typedef enum logic [1:0] {
    IAR_DST_SYS_MEM = 2'h0,
    IAR_DST_PCI_MEM = 2'h1,
    IAR_DST_ISA_MEM = 2'h3,
    IAR_DST_IO = 2'h2
  } iar_dst_t;

  // routing verdicts
  typedef enum logic [2:0] {
    IAR_RT_NONE = 3'h0,
    IAR_RT_SYS_MEM = 3'h1,
    IAR_RT_PEER = 3'h3,
    IAR_RT_OTHER_BRIDGE = 3'h2,
    IAR_RT_ISA = 3'h6,
    IAR_RT_SUBTRACTIVE = 3'h7,
    IAR_RT_IGNORE = 3'h5
  } iar_route_t;

  //////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic valid;
    iar_src_t src;
    iar_dst_t dst;
    logic [31:0] addr;
    logic addr_par;
    logic same_side;
    logic p2p_crossed;
    logic [1:0] src_bridge;
    logic [1:0] tgt_bridge;
    logic claimed;
    logic in_isa_hole;
  } iar_req_t;

  typedef struct packed {
    logic low_win_impl;
    logic low_win_en;
    logic alias_en;
    logic cross_bridge_en;
    logic [31:0] periph_mem_base;
    logic [31:0] io_region_base;
    logic [31:0] bridge_mem_base;
    logic [31:0] bridge_mem_top;
  } iar_cfg_t;

  typedef struct packed {
    logic done;
    iar_route_t route;
    logic use_alias;
    logic par_err;
    logic deny;
  } iar_res_t;

endpackage

// >>> hdl/iar_router.sv
/*
  iar_router: decides, one request per cycle, where an io-side transfer
  may go and registers the verdict one cycle later.
  assumes requests and configuration come from logic on mclk, so no
  synchronisers; bus-level signalling lives in the bus interface units.
*/
`timescale 1ns/1ps

module iar_router
  import iar_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // request and platform setup
  input wire iar_req_t req,
  input wire iar_cfg_t cfg,
  // verdict
  output iar_res_t res
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_low_win(input logic [31:0] a, input iar_cfg_t c);
    in_low_win = c.low_win_en && in_rng(a, IAR_LOW_WIN_BASE, IAR_LOW_WIN_LAST);
  endfunction

  function automatic logic is_isa_src(input iar_src_t s);
    is_isa_src = (s == IAR_SRC_ISA_DMA) || (s == IAR_SRC_ISA_MASTER);
  endfunction

  // first bridge local range; an io base of zero wraps, setup must avoid it
  function automatic logic in_first_periph(input logic [31:0] a, input iar_cfg_t c);
    in_first_periph = in_rng(a, c.periph_mem_base, c.io_region_base - 32'h1);
  endfunction

  // isa memory spans only the lowest 16 MB
  function automatic logic below_isa_mem(input logic [31:0] a);
    below_isa_mem = a < IAR_ISA_MEM_LIMIT;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // decision

  iar_res_t res_nxt;
  logic par_calc;
  logic local_peer;

  always_comb begin
    res_nxt = '0;
    res_nxt.done = req.valid;
    res_nxt.route = IAR_RT_NONE;
    par_calc = ^req.addr;
    local_peer = 1'b0;
    if (req.src_bridge == IAR_FIRST_BRIDGE) begin
      local_peer = in_first_periph(req.addr, cfg) || in_low_win(req.addr, cfg);
    end else begin
      local_peer = in_rng(req.addr, cfg.bridge_mem_base, cfg.bridge_mem_top);
    end
    // dma also reaches the first bridge range, sys mem above 16 MB and the alias
    case (req.src)
      IAR_SRC_ISA_MASTER: begin
        case (req.dst)
          IAR_DST_PCI_MEM: begin
            // window, same side, no pci bridge
            if (cfg.low_win_impl && req.same_side && !req.p2p_crossed &&
                in_low_win(req.addr, cfg)) begin
              res_nxt.route = IAR_RT_PEER;
            end
          end
          IAR_DST_SYS_MEM: begin
            // below 16 MB, holes left out
            if (below_isa_mem(req.addr) && !in_low_win(req.addr, cfg) &&
                !req.in_isa_hole) begin
              res_nxt.route = IAR_RT_SYS_MEM;
            end
          end
          default: res_nxt.route = IAR_RT_NONE;
        endcase
      end
      IAR_SRC_ISA_DMA: begin
        case (req.dst)
          IAR_DST_PCI_MEM: begin
            // base to io base, or window
            if (req.same_side && !req.p2p_crossed &&
                (in_first_periph(req.addr, cfg) || in_low_win(req.addr, cfg))) begin
              res_nxt.route = IAR_RT_PEER;
            end
          end
          IAR_DST_SYS_MEM: begin
            res_nxt.use_alias = cfg.alias_en && below_isa_mem(req.addr);
            if (!below_isa_mem(req.addr) ||
                (!in_low_win(req.addr, cfg) && !req.in_isa_hole) ||
                res_nxt.use_alias) begin
              res_nxt.route = IAR_RT_SYS_MEM;
            end
          end
          default: res_nxt.route = IAR_RT_NONE;
        endcase
      end
      IAR_SRC_HOST_BRIDGE: begin
        if (req.dst == IAR_DST_ISA_MEM && below_isa_mem(req.addr)) begin
          res_nxt.route = IAR_RT_ISA;
        end
      end
      default: begin
        case (req.dst)
          IAR_DST_ISA_MEM: begin
            if (in_low_win(req.addr, cfg)) begin
              res_nxt.route = IAR_RT_ISA;
            end
          end
          IAR_DST_PCI_MEM: begin
            if (req.same_side && local_peer) begin
              res_nxt.route = IAR_RT_PEER;
            end else if (cfg.cross_bridge_en && req.tgt_bridge != req.src_bridge &&
                         in_rng(req.addr, cfg.bridge_mem_base, cfg.bridge_mem_top)) begin
              res_nxt.route = IAR_RT_OTHER_BRIDGE;
            end else if (!req.claimed && below_isa_mem(req.addr)) begin
              // memory below 16 MB falls to isa
              res_nxt.route = IAR_RT_SUBTRACTIVE;
            end
          end
          IAR_DST_SYS_MEM: begin
            res_nxt.route = IAR_RT_SYS_MEM;
            // window on first bridge needs alias
            if (req.src_bridge == IAR_FIRST_BRIDGE && cfg.low_win_en &&
                in_rng(req.addr, IAR_LOW_WIN_BASE, IAR_LOW_WIN_LAST)) begin
              res_nxt.use_alias = 1'b1;
              if (!cfg.alias_en) begin
                res_nxt.route = IAR_RT_NONE;
              end
            end
          end
          default: begin
            if (req.same_side) begin
              res_nxt.route = IAR_RT_IGNORE;
              res_nxt.par_err = par_calc != req.addr_par;
              // io below 64 KB falls to isa
              if (!req.claimed && req.addr < IAR_ISA_IO_LIMIT) begin
                res_nxt.route = IAR_RT_SUBTRACTIVE;
              end
            end
          end
        endcase
      end
    endcase
    // isa origin never through pci bridge
    if (is_isa_src(req.src) && req.p2p_crossed) begin
      res_nxt.route = IAR_RT_NONE;
      res_nxt.use_alias = 1'b0;
    end
    res_nxt.deny = req.valid && res_nxt.route == IAR_RT_NONE;
    if (!req.valid) begin
      res_nxt = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // verdict register

  // verdict only, bus phases untouched here
  // split per concern so each field has a single owner
  logic done_r;
  logic deny_r;
  iar_route_t route_r;
  logic alias_r;
  logic par_err_r;

  // handshake: one done pulse per taken request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      done_r <= 1'b0;
      deny_r <= 1'b0;
    end else begin
      done_r <= res_nxt.done;
      deny_r <= res_nxt.deny;
    end
  end

  // routing verdict and alias choice
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      route_r <= IAR_RT_NONE;
      alias_r <= 1'b0;
    end else begin
      route_r <= res_nxt.route;
      alias_r <= res_nxt.use_alias;
    end
  end

  // parity is only flagged, the transfer itself is not stopped
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      par_err_r <= 1'b0;
    end else begin
      par_err_r <= res_nxt.par_err;
    end
  end

  // outputs wired straight from the flip-flops
  assign res = '{done: done_r, route: route_r, use_alias: alias_r, par_err: par_err_r,
                 deny: deny_r};

endmodule

// >>> sim/iar_router_assertions.sv
/* iar_router_assertions: port-level checks of the router verdicts.
   assumes it is bound to iar_router and sees only its ports. */
`timescale 1ns/1ps
module iar_router_assertions
  import iar_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // traffic
  input wire iar_req_t req,
  input wire iar_cfg_t cfg,
  input wire iar_res_t res
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic pio;
  assign pio = req.valid && req.src == IAR_SRC_PCI_MASTER && req.dst == IAR_DST_IO;
  sequence taken_s; req.valid; endsequence
  sequence answer_s; res.done; endsequence
  //////////////////////////////////////////////////////////////////////////
  a_answer_one: assert property (taken_s |=> answer_s)
    else $error("missing verdict");
  a_idle_quiet: assert property (!req.valid |=> !res.done)
    else $error("verdict without request");
  a_deny_none: assert property (res.deny == (res.done && res.route == IAR_RT_NONE))
    else $error("deny flag mismatch");
  a_isa_bridge: assert property (req.valid && req.p2p_crossed && !req.src[1]
    |=> res.route == IAR_RT_NONE) else $error("isa crossed a pci bridge");
  a_host_isa: assert property (req.valid && req.src == IAR_SRC_HOST_BRIDGE
    && req.dst == IAR_DST_ISA_MEM && req.addr < IAR_ISA_MEM_LIMIT
    |=> res.route == IAR_RT_ISA) else $error("host bridge isa miss");
  a_io_side: assert property (pio && !req.same_side |=> res.route == IAR_RT_NONE)
    else $error("io routed across sides");
  a_io_parity: assert property (pio && req.same_side
    |=> res.par_err == $past(^req.addr ^ req.addr_par)) else $error("parity flag wrong");
  a_isa_limit: assert property (req.valid && req.src == IAR_SRC_ISA_MASTER
    && req.dst == IAR_DST_SYS_MEM && req.addr >= IAR_ISA_MEM_LIMIT
    |=> res.route == IAR_RT_NONE) else $error("isa master above limit");
  a_alias_use: assert property (req.valid && req.src == IAR_SRC_PCI_MASTER
    && req.dst == IAR_DST_SYS_MEM && cfg.low_win_en && req.src_bridge == IAR_FIRST_BRIDGE
    && req.addr >= IAR_LOW_WIN_BASE && req.addr <= IAR_LOW_WIN_LAST
    |=> res.use_alias) else $error("alias not used");
endmodule

// >>> sim/iar_requester.sv
/* iar_requester: far-side requester model driving router requests.
   assumes callers enter its tasks just after a rising edge. */
`timescale 1ns/1ps
module iar_requester
  import iar_pkg::*;
(
  // bus side
  input wire logic mclk,
  output iar_req_t req
);
  initial req = '0;
  function automatic iar_req_t mk(iar_src_t s, iar_dst_t d, logic [31:0] a);
    mk = {1'b1, s, d, a, ^a, 1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0};
  endfunction
  // crossing and holes only when a scenario asks
  task automatic send(iar_req_t r);
    req = r;
  endtask
  // released address shows inverse, never the stale value
  task automatic idle();
    req.valid = 1'b0;
    req.addr = ~req.addr;
  endtask
endmodule

// >>> sim/iar_router_test.sv
/* iar_router_test: directed scenarios for the io access router.
   assumes iar_pkg, iar_router, requester and checker compile first. */
`timescale 1ns/1ps
module iar_router_test
  import iar_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  iar_cfg_t cfg;
  iar_req_t req;
  iar_res_t res;
  iar_req_t q;
  int n_errors = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  iar_requester P (.mclk(mclk), .req(req));
  iar_router DUT (.mclk(mclk), .nrst(nrst), .req(req), .cfg(cfg), .res(res));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [2:0] e, logic [2:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: expected %0h got %0h", $time, e, g);
    end
  endtask
  // requests go back to back: one taking edge, then compare
  task automatic go(iar_req_t r, iar_route_t e);
    P.send(r);
    @(posedge mclk);
    #1;
    chk(e, res.route);
    chk(3'h1, res.done);
    chk({2'h0, e == IAR_RT_NONE}, res.deny);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_isa();
    go(P.mk(IAR_SRC_ISA_MASTER, IAR_DST_PCI_MEM, 32'h000A_0000), IAR_RT_PEER);
    go(P.mk(IAR_SRC_ISA_MASTER, IAR_DST_PCI_MEM, 32'h0010_0000), IAR_RT_NONE);
    q = P.mk(IAR_SRC_ISA_DMA, IAR_DST_PCI_MEM, 32'h000F_FFFF);
    q.p2p_crossed = 1'b1;
    go(q, IAR_RT_NONE);
    go(P.mk(IAR_SRC_ISA_MASTER, IAR_DST_SYS_MEM, 32'h00FF_FFFF), IAR_RT_SYS_MEM);
    go(P.mk(IAR_SRC_ISA_MASTER, IAR_DST_SYS_MEM, 32'h0100_0000), IAR_RT_NONE);
    go(P.mk(IAR_SRC_ISA_DMA, IAR_DST_PCI_MEM, 32'h0200_0000), IAR_RT_PEER);
    go(P.mk(IAR_SRC_ISA_DMA, IAR_DST_PCI_MEM, 32'h0400_0000), IAR_RT_NONE);
    q = P.mk(IAR_SRC_ISA_DMA, IAR_DST_SYS_MEM, 32'h000B_0000);
    q.in_isa_hole = 1'b1;
    go(q, IAR_RT_SYS_MEM);
    chk(3'h1, res.use_alias);
    $display("t_isa done");
  endtask
  task automatic t_pci();
    go(P.mk(IAR_SRC_HOST_BRIDGE, IAR_DST_ISA_MEM, 32'h00FF_FFFF), IAR_RT_ISA);
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_ISA_MEM, 32'h000C_0000), IAR_RT_ISA);
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_ISA_MEM, 32'h0009_FFFF), IAR_RT_NONE);
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_PCI_MEM, 32'h03FF_FFFF), IAR_RT_PEER);
    q = P.mk(IAR_SRC_PCI_MASTER, IAR_DST_PCI_MEM, 32'h0800_0000);
    q.src_bridge = 2'h1;
    go(q, IAR_RT_PEER);
    q.same_side = 1'b0;
    q.src_bridge = 2'h0;
    q.tgt_bridge = 2'h1;
    go(q, IAR_RT_OTHER_BRIDGE);
    q = P.mk(IAR_SRC_PCI_MASTER, IAR_DST_PCI_MEM, 32'h0050_0000);
    q.same_side = 1'b0;
    go(q, IAR_RT_SUBTRACTIVE);
    q.claimed = 1'b1;
    go(q, IAR_RT_NONE);
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_SYS_MEM, 32'h000A_0000), IAR_RT_SYS_MEM);
    chk(3'h1, res.use_alias);
    cfg.alias_en = 1'b0;
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_SYS_MEM, 32'h000A_0000), IAR_RT_NONE);
    cfg.low_win_en = 1'b0;
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_ISA_MEM, 32'h000C_0000), IAR_RT_NONE);
    $display("t_pci done");
  endtask
  task automatic t_io();
    q = P.mk(IAR_SRC_PCI_MASTER, IAR_DST_IO, 32'h0000_FFFF);
    q.claimed = 1'b1;
    go(q, IAR_RT_IGNORE);
    chk(3'h0, res.par_err);
    q.addr_par = ~q.addr_par;
    go(q, IAR_RT_IGNORE);
    chk(3'h1, res.par_err);
    go(P.mk(IAR_SRC_PCI_MASTER, IAR_DST_IO, 32'h0000_1000), IAR_RT_SUBTRACTIVE);
    q.same_side = 1'b0;
    go(q, IAR_RT_NONE);
    $display("t_io done");
  endtask
  task automatic t_cfg();
    cfg.low_win_en = 1'b1;
    cfg.low_win_impl = 1'b0;
    go(P.mk(IAR_SRC_ISA_MASTER, IAR_DST_PCI_MEM, 32'h000A_0000), IAR_RT_NONE);
    cfg.low_win_impl = 1'b1;
    q = P.mk(IAR_SRC_ISA_MASTER, IAR_DST_PCI_MEM, 32'h000A_0000);
    q.same_side = 1'b0;
    go(q, IAR_RT_NONE);
    go(P.mk(IAR_SRC_ISA_MASTER, IAR_DST_SYS_MEM, 32'h000C_0000), IAR_RT_NONE);
    go(P.mk(IAR_SRC_ISA_DMA, IAR_DST_SYS_MEM, 32'h000B_0000), IAR_RT_NONE);
    chk(3'h0, res.use_alias);
    cfg.cross_bridge_en = 1'b0;
    q = P.mk(IAR_SRC_PCI_MASTER, IAR_DST_PCI_MEM, 32'h0800_0000);
    q.same_side = 1'b0;
    q.tgt_bridge = 2'h1;
    go(q, IAR_RT_NONE);
    $display("t_cfg done");
  endtask
  task automatic t_rst();
    P.send(P.mk(IAR_SRC_HOST_BRIDGE, IAR_DST_ISA_MEM, 32'h0000_1000));
    nrst = 1'b0;
    @(posedge mclk);
    #1;
    chk(3'h0, {res.done, res.deny, res.par_err});
    chk(IAR_RT_NONE, res.route);
    P.idle();
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    @(posedge mclk);
    #1;
    chk(3'h0, res.done);
    go(P.mk(IAR_SRC_HOST_BRIDGE, IAR_DST_ISA_MEM, 32'h0000_1000), IAR_RT_ISA);
    $display("t_rst done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    cfg = {4'hF, 32'h0200_0000, 32'h0400_0000, 32'h0800_0000, 32'h08FF_FFFF};
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'b1;
    @(posedge mclk);
    #1;
    chk(3'h0, {res.done, res.deny, res.par_err});
    t_isa();
    t_io();
    t_pci();
    t_cfg();
    t_rst();
    P.idle();
    @(posedge mclk);
    #1;
    chk(3'h0, res.done);
    give_verdict();
  end
  initial begin
    #10000;
    n_errors++;
    give_verdict();
  end
endmodule
bind iar_router iar_router_assertions A (.mclk(mclk), .nrst(nrst), .req(req), .cfg(cfg),
  .res(res));
